// *** logic/lcdx_pkg.sv ***
// Package: constants and carrier types of the extension instruction decoder
package lcdx_pkg;

	// Clock
	localparam int unsigned CLK_HZ = 40_000_000;

	// Instruction opcodes (upper nibble unless noted)
	localparam logic [3:0] OP_BIAS_OSC    = 4'h1;
	localparam logic [3:0] OP_ICON_ADDR   = 4'h4;
	localparam logic [3:0] OP_POWER_ICON  = 4'h5;
	localparam logic [3:0] OP_FOLLOWER    = 4'h6;
	localparam logic [3:0] OP_CONTRAST_LO = 4'h7;
	localparam logic [2:0] OP_FUNC_SET    = 3'h1;  // Upper three bits 001
	localparam logic [1:0] OP_CGRAM_ADDR  = 2'h1;  // Upper two bits 01, normal table
	localparam int unsigned DDRAM_ADDR_BIT = 7;

	// Field positions
	localparam int unsigned TABLE_SELECT_BIT = 0;
	localparam int unsigned BIAS_BIT         = 3;
	localparam int unsigned ICON_EN_BIT      = 3;
	localparam int unsigned BOOSTER_BIT      = 2;
	localparam int unsigned FOLLOWER_BIT     = 3;

	// Reset values
	localparam logic       TABLE_SELECT_RST = 1'b0;
	localparam logic       BIAS_RST         = 1'b0;
	localparam logic [2:0] OSC_TRIM_RST     = 3'h4;
	localparam logic [2:0] GAIN_RATIO_RST   = 3'h0;
	localparam logic [5:0] CONTRAST_RST     = 6'h20;
	localparam logic [6:0] ADDR_RST         = 7'h00;

	// Frame rates at 3.0 V per trim code, in Hz
	localparam int unsigned FRAME_HZ [8] = '{122, 131, 144, 161, 183, 221, 274, 347};
	localparam int unsigned FRAME_CNT_W  = 20;

	// RAM that data transfers reach
	typedef enum logic [1:0] {
		LCDX_RAM_DDRAM = 2'b00,
		LCDX_RAM_CGRAM = 2'b01,
		LCDX_RAM_ICON  = 2'b11
	} lcdx_ram_t;

	// Host bus pins
	typedef struct packed {
		logic       register_select;
		logic       rw;
		logic       enable;
		logic [7:0] data;
	} lcdx_bus_t;

	// Drive power settings
	typedef struct packed {
		logic       booster_en;
		logic       follower_en;
		logic [2:0] gain_ratio_field;
		logic [5:0] contrast_value;
	} lcdx_power_t;

	// RAM access request
	typedef struct packed {
		logic       write;
		logic       read;
		lcdx_ram_t  target;
		logic [6:0] address_counter;
		logic [7:0] data;
	} lcdx_ram_req_t;

endpackage

// *** logic/lcdx_frame_tick.sv ***
// Frame-rate tick generator steered by the oscillator trim code
`timescale 1ns/10ps
module lcdx_frame_tick #(
	parameter int unsigned CLK_HZ = lcdx_pkg::CLK_HZ
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] trim_i,
	output logic            frame_tick_o
);

	typedef struct packed {
		logic [lcdx_pkg::FRAME_CNT_W-1:0] count;
		logic                             tick;
	} lcdx_tick_state_t;

	lcdx_tick_state_t s_q;
	lcdx_tick_state_t s_d;
	logic [lcdx_pkg::FRAME_CNT_W-1:0] div_top;

	////////////////////////////////////////////////////////////////////////////
	// Eight ascending frame rates
	always_comb begin
		div_top = lcdx_pkg::FRAME_CNT_W'(CLK_HZ / lcdx_pkg::FRAME_HZ[trim_i] - 1);
	end

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.count >= div_top) begin
			s_d.count = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.count = s_q.count + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign frame_tick_o = s_q.tick;

endmodule // lcdx_frame_tick

// *** logic/lcdx_ext_decoder.sv ***
// Extension instruction decoder of the character display controller
// Function
// - Bias select high gives quarter bias, low gives fifth bias.
// - Bias select is ignored when both follower options are high.
// - Oscillator trim reaches the oscillator only with clock-source option high.
// - Trim code picks one of eight ascending frame rates, 122 to 347 Hz.
// - Opcode 0100 loads low four bits into address counter as ICON address.
// - After ICON address load, data writes and reads go to ICON RAM.
// - ICON addressing only in extension table; addresses 00h to 0Fh.
// - Opcode 0101 carries ICON enable, booster enable, contrast bits 5 and 4.
// - ICON enable high shows ICON segments, low blanks them.
// - Booster follows its bit, settable only with internal follower.
// - Six-bit contrast from two instructions, settable only with internal follower.
// - Opcode 0110 carries follower enable and three-bit gain ratio.
// - Follower follows its bit, settable only with internal follower.
// - Gain ratio accepted only with internal follower selected.
// - Extension table decoded only while table select is high.
`timescale 1ns/10ps
module lcdx_ext_decoder #(
	parameter int unsigned CLK_HZ = lcdx_pkg::CLK_HZ
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire lcdx_pkg::lcdx_bus_t     bus_i,
	input  wire logic                    follower_option_a_i,
	input  wire logic                    follower_option_b_i,
	input  wire logic                    clock_source_option_i,
	output logic                         table_select_o,
	output logic                         bias_quarter_o,
	output logic                         bias_external_o,
	output logic [2:0]                   osc_trim_o,
	output logic                         frame_tick_o,
	output logic                         icon_display_o,
	output lcdx_pkg::lcdx_power_t        power_o,
	output lcdx_pkg::lcdx_ram_req_t      ram_req_o
);

	typedef struct packed {
		lcdx_pkg::lcdx_bus_t    bus_s1;
		lcdx_pkg::lcdx_bus_t    bus_s2;
		logic                   enable_prev;
		logic [2:0]             opt_s1;
		logic [2:0]             opt_s2;
		logic                   table_select;
		logic                   bias_select;
		logic [2:0]             osc_trim_field;
		logic                   icon_en;
		lcdx_pkg::lcdx_power_t  power;
		lcdx_pkg::lcdx_ram_req_t ram;
	} lcdx_state_t;

	lcdx_state_t s_q;
	lcdx_state_t s_d;
	logic        strobe;
	logic        internal_follower;
	logic        external_bias;
	logic [7:0]  db;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, strobe on falling enable
	always_comb begin
		strobe = s_q.enable_prev & ~s_q.bus_s2.enable;
		db = s_q.bus_s2.data;
		internal_follower = ~s_q.opt_s2[0] & ~s_q.opt_s2[1];
		external_bias = s_q.opt_s2[0] & s_q.opt_s2[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction decode
	always_comb begin
		s_d = s_q;
		s_d.bus_s1 = bus_i;
		s_d.bus_s2 = s_q.bus_s1;
		s_d.enable_prev = s_q.bus_s2.enable;
		s_d.opt_s1 = {clock_source_option_i, follower_option_b_i, follower_option_a_i};
		s_d.opt_s2 = s_q.opt_s1;
		s_d.ram.write = 1'b0;
		s_d.ram.read = 1'b0;
		if (strobe && s_q.bus_s2.register_select) begin
			// Data access to the RAM picked by the last address set
			s_d.ram.write = ~s_q.bus_s2.rw;
			s_d.ram.read = s_q.bus_s2.rw;
			s_d.ram.data = db;
			if (s_q.ram.target == lcdx_pkg::LCDX_RAM_ICON) begin
				s_d.ram.address_counter = {3'h0, s_q.ram.address_counter[3:0] + 4'h1};
			end else begin
				s_d.ram.address_counter = s_q.ram.address_counter + 7'h01;
			end
		end else if (strobe && !s_q.bus_s2.rw) begin
			if (db[lcdx_pkg::DDRAM_ADDR_BIT]) begin
				s_d.ram.target = lcdx_pkg::LCDX_RAM_DDRAM;
				s_d.ram.address_counter = db[6:0];
			end else if (db[7:5] == lcdx_pkg::OP_FUNC_SET) begin
				s_d.table_select = db[lcdx_pkg::TABLE_SELECT_BIT];
			end else if (!s_q.table_select) begin
				// Normal table: only the CGRAM address set concerns this block
				if (db[7:6] == lcdx_pkg::OP_CGRAM_ADDR) begin
					s_d.ram.target = lcdx_pkg::LCDX_RAM_CGRAM;
					s_d.ram.address_counter = {1'b0, db[5:0]};
				end
			end else if (db[7:4] == lcdx_pkg::OP_BIAS_OSC) begin
				s_d.bias_select = db[lcdx_pkg::BIAS_BIT];
				s_d.osc_trim_field = db[2:0];
			end else if (db[7:4] == lcdx_pkg::OP_ICON_ADDR) begin
				// ICON address only here, in the extension table
				s_d.ram.target = lcdx_pkg::LCDX_RAM_ICON;
				s_d.ram.address_counter = {3'h0, db[3:0]};
			end else if (db[7:4] == lcdx_pkg::OP_POWER_ICON) begin
				s_d.icon_en = db[lcdx_pkg::ICON_EN_BIT];
				if (internal_follower) begin
					s_d.power.booster_en = db[lcdx_pkg::BOOSTER_BIT];
					s_d.power.contrast_value[5:4] = db[1:0];
				end
			end else if (db[7:4] == lcdx_pkg::OP_FOLLOWER) begin
				if (internal_follower) begin
					s_d.power.follower_en = db[lcdx_pkg::FOLLOWER_BIT];
					s_d.power.gain_ratio_field = db[2:0];
				end
			end else if (db[7:4] == lcdx_pkg::OP_CONTRAST_LO) begin
				if (internal_follower) begin
					s_d.power.contrast_value[3:0] = db[3:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.table_select <= lcdx_pkg::TABLE_SELECT_RST;
			s_q.bias_select <= lcdx_pkg::BIAS_RST;
			s_q.osc_trim_field <= lcdx_pkg::OSC_TRIM_RST;
			s_q.power.gain_ratio_field <= lcdx_pkg::GAIN_RATIO_RST;
			s_q.power.contrast_value <= lcdx_pkg::CONTRAST_RST;
			s_q.ram.address_counter <= lcdx_pkg::ADDR_RST;
			s_q.ram.target <= lcdx_pkg::LCDX_RAM_DDRAM;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign table_select_o  = s_q.table_select;
	assign bias_external_o = external_bias;
	assign bias_quarter_o  = s_q.bias_select & ~external_bias;
	assign osc_trim_o      = s_q.opt_s2[2] ? s_q.osc_trim_field : lcdx_pkg::OSC_TRIM_RST;
	assign icon_display_o  = s_q.icon_en;
	assign power_o         = s_q.power;
	assign ram_req_o       = s_q.ram;

	lcdx_frame_tick #(
		.CLK_HZ       (CLK_HZ)
	) u_frame_tick (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.trim_i       (osc_trim_o),
		.frame_tick_o (frame_tick_o)
	);

endmodule // lcdx_ext_decoder

// *** tb/lcdx_ext_decoder_properties.sv ***
// Checker of the decoder port behaviour
`timescale 1ns/10ps
module lcdx_ext_decoder_properties #(
	parameter int unsigned CLK_HZ = lcdx_pkg::CLK_HZ
) (
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	input wire lcdx_pkg::lcdx_bus_t     bus_i,
	input wire logic                    follower_option_a_i,
	input wire logic                    follower_option_b_i,
	input wire logic                    clock_source_option_i,
	input wire logic                    table_select_o,
	input wire logic                    bias_quarter_o,
	input wire logic                    bias_external_o,
	input wire logic [2:0]              osc_trim_o,
	input wire logic                    frame_tick_o,
	input wire logic                    icon_display_o,
	input wire lcdx_pkg::lcdx_power_t   power_o,
	input wire lcdx_pkg::lcdx_ram_req_t ram_req_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bias_forced_a: assert property (bias_external_o |-> !bias_quarter_o)
		else $error("bias not forced");
	ext_strap_a: assert property ((follower_option_a_i && follower_option_b_i) [*3]
		|-> bias_external_o) else $error("strap not seen");
	trim_default_a: assert property ((!clock_source_option_i) [*4]
		|-> osc_trim_o == 3'h4) else $error("trim applied");
	power_guard_a: assert property ((follower_option_a_i || follower_option_b_i) [*4]
		|=> $stable(power_o)) else $error("power changed");
	tick_pulse_a: assert property (frame_tick_o |=> !frame_tick_o)
		else $error("tick too long");
	icon_cause_a: assert property ($changed(icon_display_o)
		|-> !$past(bus_i.enable, 3) && table_select_o) else $error("icon cause");
	normal_table_a: assert property (!table_select_o
		|=> $stable(icon_display_o) && $stable(power_o)) else $error("ext in normal");
	write_pulse_a: assert property (ram_req_o.write |=> !ram_req_o.write)
		else $error("write too long");
	icon_range_a: assert property (ram_req_o.target == lcdx_pkg::LCDX_RAM_ICON
		|-> ram_req_o.address_counter[6:4] == 3'h0) else $error("icon range");
	cover property (ram_req_o.write && ram_req_o.target == lcdx_pkg::LCDX_RAM_ICON);
	cover property ($rose(power_o.booster_en));
	cover property (frame_tick_o && osc_trim_o == 3'h7);
endmodule // lcdx_ext_decoder_properties
////////////////////////////////////////////////////////////////////////////////
bind lcdx_ext_decoder lcdx_ext_decoder_properties #(.CLK_HZ(CLK_HZ)) props_inst (
	.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .follower_option_a_i(follower_option_a_i),
	.follower_option_b_i(follower_option_b_i), .clock_source_option_i(clock_source_option_i),
	.table_select_o(table_select_o), .bias_quarter_o(bias_quarter_o),
	.bias_external_o(bias_external_o), .osc_trim_o(osc_trim_o), .frame_tick_o(frame_tick_o),
	.icon_display_o(icon_display_o), .power_o(power_o), .ram_req_o(ram_req_o));

// *** tb/lcdx_host_model.sv ***
// Host processor model on the instruction bus
`timescale 1ns/10ps
module lcdx_host_model (
	input wire logic            clk_i,
	output lcdx_pkg::lcdx_bus_t bus_o
);
	initial bus_o = '0;
	// One bus cycle; slow stretches both enable phases
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, input int slow);
		@(posedge clk_i) #2;
		bus_o.register_select = rs;
		bus_o.rw = rw;
		bus_o.data = d;
		bus_o.enable = 1'b1;
		repeat (3 + slow) @(posedge clk_i);
		#2 bus_o.enable = 1'b0;
		repeat (4 + slow) @(posedge clk_i);
		#2 bus_o.data = ~d; // Released lines show no stale value
		repeat (2) @(posedge clk_i);
	endtask
endmodule // lcdx_host_model

// *** tb/lcdx_ext_decoder_bench.sv ***
// Self-checking bench of the decoder
`timescale 1ns/10ps
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module lcdx_ext_decoder_bench;
	localparam int unsigned HZ = 3470;
	logic                    clk_i = 1'b0;
	logic                    rst_i = 1'b1;
	logic                    oa = 1'b0, ob = 1'b0, cs = 1'b0;
	logic                    tsel, bq, bx, tick, icon;
	logic [2:0]              trim;
	lcdx_pkg::lcdx_bus_t     bus;
	lcdx_pkg::lcdx_power_t   pwr;
	lcdx_pkg::lcdx_ram_req_t req;
	int err_count = 0, check_count = 0, cyc = 0, rd = 0, rs_n = 0, wr = 0, ws = 0, wd = 0, wv = 0;
	int ts = 0, bs = 0, tr = 4, ic = 0, bo = 0, fo = 0, ga = 0, co = 32, ad = 0, tg = 0, n;
	int ops[7] = '{1, 3, 4, 5, 6, 7, 8};
	always #12.5 clk_i = ~clk_i;
	lcdx_host_model lcdx_host_model_inst (.clk_i(clk_i), .bus_o(bus));
	lcdx_ext_decoder #(.CLK_HZ(HZ)) lcdx_ext_decoder_inst (.clk_i(clk_i), .rst_i(rst_i),
		.bus_i(bus), .follower_option_a_i(oa), .follower_option_b_i(ob),
		.clock_source_option_i(cs), .table_select_o(tsel), .bias_quarter_o(bq),
		.bias_external_o(bx), .osc_trim_o(trim), .frame_tick_o(tick), .icon_display_o(icon),
		.power_o(pwr), .ram_req_o(req));
	always @(posedge clk_i) begin
		cyc++;
		if (req.write === 1'b1) begin
			ws++;
			wv = req.data;
		end
		if (req.read === 1'b1) rs_n++;
		if (cyc == 40000) begin
			err_count++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check_all();
		`CK("table", ts, tsel)
		`CK("bias", bs && !(oa && ob), bq)
		`CK("ext", oa && ob, bx)
		`CK("trim", cs ? tr : 4, trim)
		`CK("icon", ic, icon)
		`CK("boost", bo, pwr.booster_en)
		`CK("follow", fo, pwr.follower_en)
		`CK("gain", ga, pwr.gain_ratio_field)
		`CK("contrast", co, pwr.contrast_value)
		`CK("addr", ad, req.address_counter)
		`CK("target", tg, req.target)
		`CK("writes", wr, ws)
		`CK("reads", rd, rs_n)
		`CK("wdata", wd, wv)
	endtask
	task automatic send(input logic rs, input logic rw, input logic [7:0] d);
		logic own;
		own = !oa && !ob;
		lcdx_host_model_inst.xfer(rs, rw, d, $urandom_range(0, 2));
		if (!rs && !rw) begin
			if (d[7:5] == 3'h1) ts = d[0];
			else if (d[7]) begin
				ad = d[6:0];
				tg = 0;
			end else if (!ts && d[7:6] == 2'h1) begin
				ad = d[5:0];
				tg = 1;
			end else if (ts) case (d[7:4])
				4'h1: begin bs = d[3]; tr = d[2:0]; end
				4'h4: begin ad = d[3:0]; tg = 3; end
				4'h5: begin ic = d[3]; if (own) begin bo = d[2]; co = co % 16 + d[1:0] * 16; end end
				4'h6: if (own) begin fo = d[3]; ga = d[2:0]; end
				4'h7: if (own) co = co / 16 * 16 + d[3:0];
				default: ;
			endcase
		end else if (rs) begin
			ad = (tg == 3) ? (ad + 1) % 16 : (ad + 1) % 128;
			if (rw) rd++;
			else begin
				wr++;
				wd = d;
			end
		end
		#2 check_all();
	endtask
	initial begin
		void'($urandom(98));
		repeat (10) @(posedge clk_i);
		#2 rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		#2 check_all();
		send(0, 0, 8'h5c);
		send(0, 0, 8'h21);
		cs = 1'b1;
		for (int k = 0; k < 8; k++) begin
			send(0, 0, {4'h1, 1'(k), 3'(k)});
			for (int j = 0; j < 2; j++) begin
				n = 0;
				do begin @(posedge clk_i); #1; n++; end while (tick !== 1'b1 && n < 100);
			end
			`CK("period", HZ / lcdx_pkg::FRAME_HZ[k], n)
		end
		send(0, 0, 8'h4f);
		send(1, 0, 8'ha5);
		send(1, 1, 8'h00);
		for (int i = 0; i < 70; i++) begin
			n = ops[$urandom_range(0, 6)];
			if (!ts && n == 1) n = 3;
			{oa, ob, cs} = 3'($urandom);
			repeat (4) @(posedge clk_i);
			case ($urandom_range(0, 5))
				0: send(1, 1'($urandom), 8'($urandom));
				1: send(0, 1, 8'($urandom));
				default: send(0, 0, {4'(n), 4'($urandom)});
			endcase
		end
		complete_run();
	end
endmodule // lcdx_ext_decoder_bench
